// ==== hdl/vpw_pkg.sv ====
// Shared constants and types of the pulse-width symbol receiver and arbiter
package vpw_pkg;

  // ----------------------------------------------------------------------
  // Clock and counter sizing
  // ----------------------------------------------------------------------
  localparam int unsigned VPW_CLK_MHZ             = 25;
  localparam int unsigned VPW_MUX_CLOCK_PERIOD_NS = 40;
  localparam int unsigned VPW_CNT_W               = 16;
  localparam int unsigned VPW_DATA_W              = 8;
  localparam int unsigned VPW_FIFO_DEPTH          = 32;
  localparam logic [2:0]  VPW_LAST_BIT            = 3'h7;

  // ----------------------------------------------------------------------
  // Receive windows in microseconds
  // ----------------------------------------------------------------------
  localparam int unsigned VPW_PAS_A_US = 34;
  localparam int unsigned VPW_PAS_B_US = 96;
  localparam int unsigned VPW_PAS_C_US = 163;
  localparam int unsigned VPW_PAS_D_US = 239;
  localparam int unsigned VPW_EOF_US   = 280;
  localparam int unsigned VPW_IFS_US   = 300;
  localparam int unsigned VPW_ACT_A_US = 34;
  localparam int unsigned VPW_ACT_B_US = 96;
  localparam int unsigned VPW_ACT_C_US = 163;
  localparam int unsigned VPW_ACT_D_US = 239;
  localparam int unsigned VPW_ACT_E_US = 240;
  // Nominal transmit lengths in microseconds
  localparam int unsigned VPW_T64_US   = 64;
  localparam int unsigned VPW_T128_US  = 128;
  localparam int unsigned VPW_T200_US  = 200;

  // ----------------------------------------------------------------------
  // Same windows in clock cycles
  // ----------------------------------------------------------------------
  localparam int unsigned VPW_PAS_A_CYC = VPW_PAS_A_US * VPW_CLK_MHZ;
  localparam int unsigned VPW_PAS_B_CYC = VPW_PAS_B_US * VPW_CLK_MHZ;
  localparam int unsigned VPW_PAS_C_CYC = VPW_PAS_C_US * VPW_CLK_MHZ;
  localparam int unsigned VPW_PAS_D_CYC = VPW_PAS_D_US * VPW_CLK_MHZ;
  localparam int unsigned VPW_EOF_CYC   = VPW_EOF_US * VPW_CLK_MHZ;
  localparam int unsigned VPW_IFS_CYC   = VPW_IFS_US * VPW_CLK_MHZ;
  localparam int unsigned VPW_ACT_A_CYC = VPW_ACT_A_US * VPW_CLK_MHZ;
  localparam int unsigned VPW_ACT_B_CYC = VPW_ACT_B_US * VPW_CLK_MHZ;
  localparam int unsigned VPW_ACT_C_CYC = VPW_ACT_C_US * VPW_CLK_MHZ;
  localparam int unsigned VPW_ACT_D_CYC = VPW_ACT_D_US * VPW_CLK_MHZ;
  localparam int unsigned VPW_ACT_E_CYC = VPW_ACT_E_US * VPW_CLK_MHZ;
  localparam int unsigned VPW_T64_CYC   = VPW_T64_US * VPW_CLK_MHZ;
  localparam int unsigned VPW_T128_CYC  = VPW_T128_US * VPW_CLK_MHZ;
  localparam int unsigned VPW_T200_CYC  = VPW_T200_US * VPW_CLK_MHZ;
  // Late-write limit, already counted in mux clock periods
  localparam int unsigned VPW_LATE_CYC  = 104;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                  last;
    logic [VPW_DATA_W-1:0] data;
  } vpw_txw_t;

  typedef enum logic [3:0] {
    SYM_NONE, SYM_INVALID, SYM_ZERO, SYM_ONE, SYM_SOF,
    SYM_EOD, SYM_EOF, SYM_IFS, SYM_BREAK
  } vpw_sym_t;

  typedef enum logic [2:0] {
    TX_IDLE, TX_SOF, TX_BIT, TX_RESYNC, TX_FLUSH
  } vpw_txst_t;

endpackage : vpw_pkg

// ==== hdl/vpw_fifo.sv ====
// Parameterised word FIFO with valid and ready on both sides
`timescale 1ns/1ns
module vpw_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data  = mem[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= rd_q + AW'(1);
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + (AW+1)'(1);
      end else if (pop && !push) begin
        cnt_q <= cnt_q - (AW+1)'(1);
      end
    end
  end

endmodule : vpw_fifo

// ==== hdl/vpw_sym_arb.sv ====
// Pulse-width bus symbol classifier, transmit timing and bitwise arbitration
//
// What this block does
// RQ1 - 280 us passive after active marks end-of-frame
// RQ2 - EOD without response becomes EOF 80 us later
// RQ3 - Separation is 300 us passive: EOF plus 20
// RQ4 - Passive longer than 300 us means idle bus
// RQ5 - Symbol windows resolved to one clock cycle
// RQ6 - Passive ends: invalid, zero, one, end-of-data
// RQ7 - Edge after EOF window: EOF, later EOF+IFS
// RQ8 - Never start before separation time expires
// RQ9 - Pending sender joins any edge after valid EOF
// RQ10 - No edge before last threshold: idle, start
// RQ11 - Active ends: invalid, one, zero, start-of-frame
// RQ12 - Active past threshold E is a break
// RQ13 - Break sender follows it with start-of-frame; this block never sends a break
// RQ14 - Defer while another message runs until idle
// RQ15 - Arbitration starts at first bit after SOF
// RQ16 - Write within 104 cycles of edge: transmit
// RQ17 - Later write waits for next separation expiry
// RQ18 - Logic zero dominates logic one on bus
// RQ19 - Recessive sent, dominant seen: stop at once
// RQ20 - Loser waits for idle bus before retrying
// RQ21 - Loss on eighth bit appends two arbitrated ones
// RQ22 - Second appended one dropped if first loses
// RQ23 - Zero is 64 us passive or 128 active
// RQ24 - One is 128 us passive or 64 active
// RQ25 - Start-of-frame is 200 us active
// RQ26 - Break is at least 240 us active
// RQ27 - Thresholds held as cycle-count constants
`timescale 1ns/1ns
module vpw_sym_arb
  import vpw_pkg::*;
#(
  parameter logic [VPW_CNT_W-1:0] P_PAS_A = VPW_CNT_W'(VPW_PAS_A_CYC),
  parameter logic [VPW_CNT_W-1:0] P_PAS_B = VPW_CNT_W'(VPW_PAS_B_CYC),
  parameter logic [VPW_CNT_W-1:0] P_PAS_C = VPW_CNT_W'(VPW_PAS_C_CYC),
  parameter logic [VPW_CNT_W-1:0] P_PAS_D = VPW_CNT_W'(VPW_PAS_D_CYC),
  parameter logic [VPW_CNT_W-1:0] P_EOF   = VPW_CNT_W'(VPW_EOF_CYC),
  parameter logic [VPW_CNT_W-1:0] P_IFS   = VPW_CNT_W'(VPW_IFS_CYC),
  parameter logic [VPW_CNT_W-1:0] P_ACT_A = VPW_CNT_W'(VPW_ACT_A_CYC),
  parameter logic [VPW_CNT_W-1:0] P_ACT_B = VPW_CNT_W'(VPW_ACT_B_CYC),
  parameter logic [VPW_CNT_W-1:0] P_ACT_C = VPW_CNT_W'(VPW_ACT_C_CYC),
  parameter logic [VPW_CNT_W-1:0] P_ACT_D = VPW_CNT_W'(VPW_ACT_D_CYC),
  parameter logic [VPW_CNT_W-1:0] P_ACT_E = VPW_CNT_W'(VPW_ACT_E_CYC),
  parameter logic [VPW_CNT_W-1:0] P_T64   = VPW_CNT_W'(VPW_T64_CYC),
  parameter logic [VPW_CNT_W-1:0] P_T128  = VPW_CNT_W'(VPW_T128_CYC),
  parameter logic [VPW_CNT_W-1:0] P_T200  = VPW_CNT_W'(VPW_T200_CYC),
  parameter logic [VPW_CNT_W-1:0] P_LATE  = VPW_CNT_W'(VPW_LATE_CYC),
  parameter int unsigned          P_DEPTH = VPW_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic      REF_CLK,
  input  wire logic      SYS_RST,
  // Bus line, high means active
  input  wire logic      BUS_RECEIVE_INPUT,
  output logic           BUS_TX,
  // Transmit words
  input  wire logic      TX_DATA_VALID,
  output logic           TX_DATA_READY,
  input  wire vpw_txw_t  TX_DATA_WORD,
  // Received symbols
  output logic           SYM_VALID,
  output vpw_sym_t       SYM_CODE,
  output logic           BUS_IDLE,
  // Transmit status
  output logic           TX_BUSY,
  output logic           TX_DONE,
  output logic           TX_LOST
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  localparam int unsigned TW = $bits(vpw_txw_t);

  logic                 rx_q;
  logic [VPW_CNT_W-1:0] cnt_q;
  logic                 edge_w;
  vpw_sym_t             sym_d;
  logic                 eof_seen_q;
  logic                 sync_open_w;
  logic                 ifs_ok_w;
  logic                 q_vld;
  logic                 pop_w;
  vpw_txw_t             q_word;
  vpw_txst_t            st_q;
  logic                 ph_act_q;
  logic                 ph_one_q;
  logic                 app_q;
  logic                 app2_q;
  logic                 nxt_act_q;
  logic                 last_q;
  logic [VPW_DATA_W-1:0] shf_q;
  logic [2:0]           bit_q;
  logic [VPW_CNT_W-1:0] tmr_q;
  logic [VPW_CNT_W-1:0] dur_w;
  logic [VPW_CNT_W-1:0] min_w;
  logic                 loss_w;
  logic                 brk_w;
  logic                 start_w;
  logic                 bit_end_w;
  logic                 drive_d;

  // ----------------------------------------------------------------------
  // Transmit word buffer
  // ----------------------------------------------------------------------
  vpw_fifo #(
    .WIDTH (TW),
    .DEPTH (P_DEPTH)
  ) u_txq (
    .clk       (REF_CLK),
    .rst       (SYS_RST),
    .in_valid  (TX_DATA_VALID),
    .in_ready  (TX_DATA_READY),
    .in_data   (TX_DATA_WORD),
    .out_valid (q_vld),
    .out_ready (pop_w),
    .out_data  (q_word)
  );

  // ----------------------------------------------------------------------
  // Level timer
  // ----------------------------------------------------------------------
  assign edge_w = BUS_RECEIVE_INPUT != rx_q;

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rx_q  <= 1'h0;
      cnt_q <= '0;
    end else begin
      rx_q <= BUS_RECEIVE_INPUT;
      if (edge_w) begin
        cnt_q <= '0;
      end else if (cnt_q != '1) begin
        cnt_q <= cnt_q + VPW_CNT_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Symbol classification
  // ----------------------------------------------------------------------
  // Comparisons against the next window's start give one-cycle seams
  always_comb begin
    sym_d = SYM_NONE;
    if (edge_w && !rx_q) begin
      if (cnt_q < P_PAS_A) begin // RQ6 RQ5 RQ27
        sym_d = SYM_INVALID;
      end else if (cnt_q < P_PAS_B) begin // RQ23
        sym_d = SYM_ZERO;
      end else if (cnt_q < P_PAS_C) begin // RQ24
        sym_d = SYM_ONE;
      end else if (cnt_q < P_PAS_D) begin
        sym_d = SYM_EOD;
      end else if (cnt_q < P_EOF) begin // RQ7
        sym_d = SYM_EOF;
      end else if (cnt_q <= P_IFS) begin // RQ7
        sym_d = SYM_IFS;
      end
    end else if (edge_w && rx_q) begin
      if (cnt_q < P_ACT_A) begin // RQ11 RQ5
        sym_d = SYM_INVALID;
      end else if (cnt_q < P_ACT_B) begin // RQ24
        sym_d = SYM_ONE;
      end else if (cnt_q < P_ACT_C) begin // RQ23
        sym_d = SYM_ZERO;
      end else if (cnt_q < P_ACT_D) begin // RQ25
        sym_d = SYM_SOF;
      end else if (cnt_q <= P_ACT_E) begin
        sym_d = SYM_INVALID;
      end
    end else if (!rx_q && cnt_q == P_EOF) begin // RQ1 RQ2
      sym_d = SYM_EOF;
    end else if (!rx_q && cnt_q == P_IFS) begin // RQ3
      sym_d = SYM_IFS;
    end else if (rx_q && cnt_q == P_ACT_E) begin // RQ12 RQ26
      sym_d = SYM_BREAK;
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      SYM_VALID <= 1'h0;
      SYM_CODE  <= SYM_NONE;
      BUS_IDLE  <= 1'h0;
    end else begin
      SYM_VALID <= sym_d != SYM_NONE;
      SYM_CODE  <= sym_d;
      BUS_IDLE  <= !rx_q && cnt_q > P_IFS; // RQ4
    end
  end

  // ----------------------------------------------------------------------
  // Frame-boundary tracking
  // ----------------------------------------------------------------------
  // Open from a valid end-of-frame until the late-write limit of the next edge
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      eof_seen_q <= 1'h0;
    end else if (sym_d == SYM_EOF || sym_d == SYM_IFS || BUS_IDLE) begin
      eof_seen_q <= 1'h1;
    end else if (rx_q && cnt_q > P_LATE) begin
      eof_seen_q <= 1'h0;
    end
  end

  assign sync_open_w = eof_seen_q && rx_q && cnt_q <= P_LATE; // RQ9 RQ16 RQ17
  assign ifs_ok_w    = !rx_q && cnt_q >= P_IFS; // RQ8 RQ10 RQ20
  assign start_w     = q_vld && (ifs_ok_w || sync_open_w); // RQ14

  // ----------------------------------------------------------------------
  // Bit timing and arbitration
  // ----------------------------------------------------------------------
  assign dur_w = ph_act_q ? (ph_one_q ? P_T64 : P_T128) : (ph_one_q ? P_T128 : P_T64);
  assign min_w = ph_one_q ? P_PAS_B : P_PAS_A;
  assign brk_w = sym_d == SYM_BREAK;

  // Bus active while holding passive, or still active after own one released
  assign loss_w = st_q == TX_BIT &&
                  ((!ph_act_q && rx_q && tmr_q < min_w) ||
                   (ph_act_q && ph_one_q && rx_q && tmr_q >= P_ACT_B)); // RQ18 RQ19 RQ15

  assign bit_end_w = ph_act_q ? (!rx_q && tmr_q >= dur_w)
                              : (rx_q || tmr_q + VPW_CNT_W'(1) >= dur_w);

  always_comb begin
    pop_w = 1'h0;
    if (st_q == TX_IDLE) begin
      pop_w = start_w;
    end else if (st_q == TX_BIT) begin
      pop_w = !brk_w && !loss_w && bit_end_w && !app_q &&
              bit_q == VPW_LAST_BIT && !last_q && q_vld;
    end else if (st_q == TX_FLUSH) begin
      pop_w = !last_q && q_vld;
    end
  end

  // ----------------------------------------------------------------------
  // Transmit sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_q      <= TX_IDLE;
      ph_act_q  <= 1'h0;
      ph_one_q  <= 1'h0;
      app_q     <= 1'h0;
      app2_q    <= 1'h0;
      nxt_act_q <= 1'h0;
      last_q    <= 1'h0;
      shf_q     <= '0;
      bit_q     <= '0;
      tmr_q     <= '0;
      TX_DONE   <= 1'h0;
      TX_LOST   <= 1'h0;
    end else begin
      TX_DONE <= 1'h0;
      TX_LOST <= 1'h0;
      unique case (st_q)
        TX_IDLE: begin
          if (start_w) begin // RQ9 RQ10 RQ16
            st_q     <= TX_SOF;
            shf_q    <= q_word.data;
            last_q   <= q_word.last;
            bit_q    <= '0;
            ph_act_q <= 1'h0;
            ph_one_q <= q_word.data[VPW_DATA_W-1];
            app_q    <= 1'h0;
            tmr_q    <= sync_open_w ? cnt_q : '0;
          end
        end
        TX_SOF: begin
          tmr_q <= tmr_q + VPW_CNT_W'(1);
          if (brk_w) begin
            st_q    <= TX_FLUSH;
            TX_LOST <= 1'h1;
          end else if (tmr_q >= P_T200 && !rx_q) begin // RQ25 RQ15
            st_q  <= TX_BIT;
            tmr_q <= '0;
          end
        end
        TX_BIT: begin
          tmr_q <= tmr_q + VPW_CNT_W'(1);
          if (brk_w) begin
            st_q    <= TX_FLUSH;
            TX_LOST <= 1'h1;
          end else if (loss_w) begin
            TX_LOST <= !app_q;
            if (bit_q == VPW_LAST_BIT && !app_q) begin // RQ21
              st_q      <= TX_RESYNC;
              app_q     <= 1'h1;
              app2_q    <= 1'h1;
              nxt_act_q <= !ph_act_q;
            end else begin // RQ19 RQ22 RQ20
              st_q <= TX_FLUSH;
            end
          end else if (bit_end_w) begin
            ph_act_q <= !ph_act_q;
            tmr_q    <= '0;
            if (app_q) begin
              if (app2_q) begin // RQ21
                app2_q   <= 1'h0;
                ph_one_q <= 1'h1;
              end else begin
                st_q <= TX_FLUSH;
              end
            end else if (bit_q != VPW_LAST_BIT) begin
              bit_q    <= 3'(bit_q + 3'h1);
              ph_one_q <= shf_q[VPW_DATA_W-2];
              shf_q    <= {shf_q[VPW_DATA_W-2:0], 1'h0};
            end else if (!last_q && q_vld) begin
              bit_q    <= '0;
              shf_q    <= q_word.data;
              last_q   <= q_word.last;
              ph_one_q <= q_word.data[VPW_DATA_W-1];
            end else begin
              st_q    <= TX_IDLE;
              TX_DONE <= 1'h1;
            end
          end
        end
        TX_RESYNC: begin
          if (rx_q == nxt_act_q) begin // RQ21
            st_q     <= TX_BIT;
            ph_act_q <= nxt_act_q;
            ph_one_q <= 1'h1;
            tmr_q    <= '0;
          end
        end
        TX_FLUSH: begin
          if (last_q) begin // RQ20
            st_q <= TX_IDLE;
          end else if (q_vld) begin
            last_q <= q_word.last;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Line driver
  // ----------------------------------------------------------------------
  assign drive_d = (st_q == TX_SOF && tmr_q < P_T200) ||
                   (st_q == TX_BIT && ph_act_q && tmr_q < dur_w); // RQ23 RQ24 RQ25

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      BUS_TX <= 1'h0;
    end else begin
      BUS_TX <= drive_d;
    end
  end

  assign TX_BUSY = st_q != TX_IDLE;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_sof_drive;
    st_q == TX_SOF ##1 BUS_TX;
  endsequence

  sequence s_lost_plain;
    loss_w && !(bit_q == VPW_LAST_BIT && !app_q);
  endsequence

  eof_mark_a: assert property ( // RQ1 RQ2
    !rx_q && !edge_w && cnt_q == P_EOF |=> SYM_VALID && SYM_CODE == SYM_EOF)
    else $error("EOF not marked at 280 us passive");
  ifs_mark_a: assert property ( // RQ3
    !rx_q && !edge_w && cnt_q == P_IFS |=> SYM_VALID && SYM_CODE == SYM_IFS)
    else $error("IFS not marked at 300 us passive");
  idle_rise_a: assert property ( // RQ4
    $rose(BUS_IDLE) |-> $past(cnt_q, 2) == P_IFS && !$past(rx_q, 2))
    else $error("Idle rose at wrong passive length");
  bit_seam_a: assert property ( // RQ5
    edge_w && !rx_q && (cnt_q == P_PAS_B || cnt_q + VPW_CNT_W'(1) == P_PAS_B) |=>
      SYM_CODE == (($past(cnt_q) == P_PAS_B) ? SYM_ONE : SYM_ZERO))
    else $error("Zero/one seam not one cycle");
  eod_class_a: assert property ( // RQ6
    edge_w && !rx_q && cnt_q >= P_PAS_C && cnt_q < P_PAS_D |=> SYM_CODE == SYM_EOD)
    else $error("Passive EOD window misclassified");
  ifs_edge_a: assert property ( // RQ7
    edge_w && !rx_q && cnt_q >= P_EOF && cnt_q <= P_IFS |=> SYM_CODE == SYM_IFS)
    else $error("Late edge not EOF plus IFS");
  ifs_wait_a: assert property ( // RQ8
    st_q == TX_IDLE && !rx_q && cnt_q < P_IFS |=> st_q == TX_IDLE)
    else $error("Start before separation expired");
  sync_start_a: assert property ( // RQ9 RQ16
    st_q == TX_IDLE && q_vld && eof_seen_q && rx_q && cnt_q <= P_LATE |=> s_sof_drive)
    else $error("Pending frame did not join edge");
  sof_class_a: assert property ( // RQ11
    edge_w && rx_q && cnt_q >= P_ACT_C && cnt_q < P_ACT_D |=> SYM_CODE == SYM_SOF)
    else $error("Active SOF window misclassified");
  break_mark_a: assert property ( // RQ12
    rx_q && !edge_w && cnt_q == P_ACT_E |=> SYM_VALID && SYM_CODE == SYM_BREAK)
    else $error("Break not marked");
  late_defer_a: assert property ( // RQ14 RQ17
    st_q == TX_IDLE && rx_q && !(eof_seen_q && cnt_q <= P_LATE) |=> st_q == TX_IDLE)
    else $error("Started inside a running frame");
  arb_stop_a: assert property ( // RQ19
    s_lost_plain |=> st_q == TX_FLUSH ##0 (!BUS_TX) [*2])
    else $error("Did not stop after arbitration loss");
  append_a: assert property ( // RQ21
    loss_w && bit_q == VPW_LAST_BIT && !app_q |=> st_q == TX_RESYNC && app2_q)
    else $error("Eighth-bit loss did not append ones");
  append_stop_a: assert property ( // RQ22
    loss_w && app_q |=> st_q == TX_FLUSH && !TX_LOST)
    else $error("Appended one kept sending after loss");

endmodule : vpw_sym_arb

// ==== dv/vpw_node_model.sv ====
// Behavioural model of another node on the pulse-width bus
`timescale 1ns/1ns
module vpw_node_model #(
  parameter int T64  = 64,
  parameter int T128 = 128,
  parameter int T200 = 200
) (
  // Clock and bus drive, high means active
  input  wire logic clk,
  output logic      drv
);
  initial drv = 1'b0;
  // One level held for n cycles
  task automatic hold(input logic lvl, input int n);
    @(posedge clk);
    #1 drv = lvl;
    repeat (n - 1) @(posedge clk);
  endtask : hold
  // Whole message, MSB first, each byte opens passive
  task automatic send_msg(input logic [7:0] b[$]);
    hold(1'b1, T200);
    foreach (b[i]) for (int k = 7; k >= 0; k--)
      hold(!k[0], (b[i][k] ^ !k[0]) ? T128 : T64);
    @(posedge clk);
    #1 drv = 1'b0;
  endtask : send_msg
endmodule : vpw_node_model

// ==== dv/test_vpw_symbol_rx_and_arbitration.sv ====
// Self-checking bench of the symbol receiver and arbiter
`timescale 1ns/1ns
module test_vpw_symbol_rx_and_arbitration
  import vpw_pkg::*;
;
  localparam logic [VPW_CNT_W-1:0] p_a = 16'h0022, p_b = 16'h0060, p_c = 16'h00A3;
  localparam logic [VPW_CNT_W-1:0] p_d = 16'h00EF, p_eof = 16'h0118, p_ifs = 16'h012C;
  logic       ref_clk, sys_rst, tx_v, mon_on, bus_rx;
  vpw_txw_t   tx_w;
  vpw_sym_t   s_code;
  wire logic  node_drv, bus_tx, rdy, s_v, idle, busy, done, lost;
  vpw_sym_t   sym_q[$];
  logic [7:0] evt_q[$];
  logic [7:0] d[$];
  int         n_fail, checks_done, seed;
  int         pl[9] = '{33, 34, 95, 96, 162, 163, 238, 250, 290};
  int         al[9] = '{33, 34, 95, 96, 162, 163, 238, 239, 200};
  // Wired bus, active dominates
  assign bus_rx = bus_tx | node_drv;
  vpw_sym_arb #(.P_PAS_A(p_a), .P_PAS_B(p_b), .P_PAS_C(p_c), .P_PAS_D(p_d), .P_EOF(p_eof),
    .P_IFS(p_ifs), .P_ACT_A(p_a), .P_ACT_B(p_b), .P_ACT_C(p_c), .P_ACT_D(p_d),
    .P_ACT_E(16'h00F0), .P_T64(16'h0040), .P_T128(16'h0080), .P_T200(16'h00C8)) dut_u (
    .REF_CLK(ref_clk), .SYS_RST(sys_rst), .BUS_RECEIVE_INPUT(bus_rx), .BUS_TX(bus_tx),
    .TX_DATA_VALID(tx_v), .TX_DATA_READY(rdy), .TX_DATA_WORD(tx_w), .SYM_VALID(s_v),
    .SYM_CODE(s_code), .BUS_IDLE(idle), .TX_BUSY(busy), .TX_DONE(done), .TX_LOST(lost));
  vpw_node_model node_u (.clk(ref_clk), .drv(node_drv));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // ------
  // Checking
  // ------
  task automatic cmp_sym(input vpw_sym_t got, input vpw_sym_t exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: symbol %0d, expected %0d", $time, got, exp);
    end
  endtask : cmp_sym
  task automatic cmp_flag(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask : cmp_flag
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  always @(negedge ref_clk) begin
    if (mon_on && s_v === 1'b1) begin
      if (sym_q.size() == 0) cmp_flag(8'hEE, 8'h00);
      else cmp_sym(s_code, sym_q.pop_front());
    end
    if (mon_on && (done === 1'b1 || lost === 1'b1)) begin
      if (evt_q.size() == 0) cmp_flag(8'hEE, 8'h00);
      else cmp_flag({6'h00, done, lost}, evt_q.pop_front());
    end
  end
  initial begin
    #3000000;
    n_fail++;
    report_and_stop();
  end
  // ------
  // Stimulus
  // ------
  function automatic vpw_sym_t pas_sym(input int l);
    if (l < p_a) return SYM_INVALID;
    if (l < p_b) return SYM_ZERO;
    if (l < p_c) return SYM_ONE;
    if (l < p_d) return SYM_EOD;
    return (l < p_eof) ? SYM_EOF : SYM_IFS;
  endfunction : pas_sym
  function automatic vpw_sym_t act_sym(input int l);
    if (l < p_a || l >= p_d) return SYM_INVALID;
    if (l < p_b) return SYM_ONE;
    return (l < p_c) ? SYM_ZERO : SYM_SOF;
  endfunction : act_sym
  task automatic pulse(input logic lvl, input int l);
    if (lvl) sym_q.push_back(act_sym(l));
    else begin
      if (l > p_eof) sym_q.push_back(SYM_EOF);
      sym_q.push_back(pas_sym(l));
    end
    // Length is the counter value seen at the closing edge
    node_u.hold(lvl, l + 1);
  endtask : pulse
  task automatic push_msg(input logic [7:0] b[$]);
    sym_q.push_back(SYM_SOF);
    foreach (b[i]) for (int k = 7; k >= 0; k--) sym_q.push_back(b[i][k] ? SYM_ONE : SYM_ZERO);
    sym_q.push_back(SYM_EOF);
    sym_q.push_back(SYM_IFS);
  endtask : push_msg
  task automatic put(input vpw_txw_t w);
    int t;
    t = 0;
    tx_v = 1'b1;
    tx_w = w;
    while (rdy !== 1'b1 && t < 500) begin
      @(posedge ref_clk);
      #1;
      t++;
    end
    if (t >= 500) n_fail++;
    @(posedge ref_clk);
    #1;
  endtask : put
  task automatic wait_idle();
    int t;
    t = 0;
    while ((idle !== 1'b1 || sym_q.size() != 0) && t < 40000) begin
      @(posedge ref_clk);
      t++;
    end
    cmp_flag({7'h00, idle}, 8'h01);
    cmp_flag(8'(sym_q.size()), 8'h00);
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : wait_idle
  task automatic arb(input logic [7:0] mine, input logic [7:0] theirs[$], input int w);
    push_msg(theirs);
    if (w > 104) push_msg({mine});
    evt_q.push_back((w > 104) ? 8'h02 : 8'h01);
    fork
      node_u.send_msg(theirs);
    join_none
    @(posedge ref_clk);
    repeat (w) @(posedge ref_clk);
    #1;
    put('{last: 1'b1, data: mine});
    tx_v = 1'b0;
    wait fork;
    wait_idle();
    $display("test arbitration %h done", mine);
  endtask : arb
  initial begin
    seed = 26;
    sys_rst = 1'b1;
    tx_v = 1'b0;
    tx_w = '0;
    mon_on = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    repeat (290) @(posedge ref_clk);
    cmp_flag({7'h00, idle}, 8'h00);
    wait_idle();
    mon_on = 1'b1;
    pulse(1'b1, 200);
    foreach (pl[i]) begin
      pulse(1'b0, pl[i]);
      pulse(1'b1, al[i]);
    end
    repeat (6) begin
      pulse(1'b0, 34 + ($unsigned($random(seed)) % 205));
      pulse(1'b1, 34 + ($unsigned($random(seed)) % 205));
    end
    pulse(1'b0, 310);
    wait_idle();
    $display("test windows done");
    arb(8'hFF, {8'h00}, 50);
    arb(8'h01, {8'h00, 8'h00}, 20);
    arb(8'h00, {8'hFF}, 150);
    sym_q.push_back(SYM_BREAK);
    sym_q.push_back(SYM_EOF);
    sym_q.push_back(SYM_IFS);
    fork
      node_u.hold(1'b1, 260);
    join_none
    repeat (120) @(posedge ref_clk);
    #1;
    for (int i = 0; i < 32; i++) begin
      d.push_back(8'($random(seed)));
      put('{last: (i == 31), data: d[i]});
    end
    cmp_flag({7'h00, rdy}, 8'h00);
    cmp_flag({7'h00, busy}, 8'h00);
    tx_v = 1'b0;
    push_msg(d);
    evt_q.push_back(8'h02);
    wait fork;
    node_u.hold(1'b0, 1);
    wait_idle();
    $display("test break and fill done");
    cmp_flag(8'(evt_q.size()), 8'h00);
    report_and_stop();
  end
endmodule : test_vpw_symbol_rx_and_arbitration
